// [core/csb_pkg.sv]
package csb_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] ADDR_BANK_SELECT = 8'h04;
    localparam logic [7:0] ADDR_STATUS_FLAGS = 8'h0A;
    localparam logic [7:0] ADDR_WORK_REG = 8'h05;
    localparam logic [7:0] ADDR_PROG_INDEX_LOW = 8'h06;
    localparam logic [7:0] ADDR_TABLE_PTR_LOW = 8'h07;
    localparam logic [7:0] ADDR_TABLE_PTR_HIGH = 8'h08;
    localparam logic [7:0] ADDR_TABLE_RESULT_HIGH = 8'h09;
    // special-function area spans this many addresses in every bank
    localparam logic [7:0] SFR_LIMIT = 8'h80;
    // status bit positions
    localparam int STAT_CARRY = 0;
    localparam int STAT_NIBBLE = 1;
    localparam int STAT_NIL = 2;
    localparam int STAT_WRAP = 3;
    localparam int STAT_HALTED = 4;
    localparam int STAT_EXPIRY = 5;
    localparam logic [7:0] STAT_SW_MASK = 8'h0F;
    localparam logic [1:0] BANK_RESET = 2'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // affected-flag mask bits supplied with each alu operation
    localparam int AFF_C = 0;
    localparam int AFF_AC = 1;
    localparam int AFF_Z = 2;
    localparam int AFF_OV = 3;
    // alu operation codes
    typedef enum logic [3:0] {
        CSB_OP_ADD = 4'h0,
        CSB_OP_ADC = 4'h1,
        CSB_OP_SUB = 4'h2,
        CSB_OP_SBC = 4'h3,
        CSB_OP_AND = 4'h4,
        CSB_OP_OR = 4'h5,
        CSB_OP_XOR = 4'h6,
        CSB_OP_RLC = 4'h7,
        CSB_OP_RRC = 4'h8,
        CSB_OP_PASS = 4'h9
    } csb_op_t;
    // jump sequencer states
    typedef enum logic [1:0] {
        CSB_ST_RUN = 2'b00,
        CSB_ST_DUMMY = 2'b01
    } csb_state_t;
endpackage : csb_pkg

// [core/csb_core.sv]
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - bank_pointer low two bits pick data bank zero to three.
// - resets return bank to zero, except watchdog expiry while idle or asleep.
// - special-function area decodes the same in every bank.
// - direct accesses hit bank zero; other banks only via indirect addressing.
// - bank_pointer upper six bits read zero.
// - alu results land in working_register; no register-to-register path.
// - writing prog_index_low jumps inside current page with one dummy cycle.
// - table read puts high byte in table_result_high, low byte to destination.
// - software status writes change arithmetic flags only.
// - carry set on add carry or subtract no-borrow; rotates update it.
// - nibble carry set on low-nibble carry or no nibble borrow.
// - result_nil_flag set when result is zero, else cleared.
// - signed_wrap_flag set when carry into msb differs from carry out.
// - halted_flag cleared by power-up or watchdog clear, set by halt.
// - expiry flag cleared by power-up, watchdog clear, halt; set on timeout.
// - status never stacked on calls or interrupts; only return address.
// - at power-up expiry and halted read zero, upper status bits zero.
module csb_core #(
    parameter int PC_WIDTH = 13
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic power_up_in,
    input wire logic wdt_reset_in,
    input wire logic low_power_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic alu_go_in,
    input wire logic [3:0] alu_op_in,
    input wire logic [7:0] alu_operand_in,
    input wire logic [3:0] alu_affect_in,
    input wire logic wdt_clear_in,
    input wire logic halt_in,
    input wire logic wdt_timeout_in,
    input wire logic [7:0] mem_addr_in,
    input wire logic mem_indirect_in,
    input wire logic tbl_go_in,
    input wire logic [15:0] tbl_data_in,
    input wire logic [PC_WIDTH-1:0] pc_in,
    output logic [7:0] reg_rdata_out,
    output logic [7:0] working_reg_out,
    output logic [7:0] table_low_out,
    output logic table_low_valid_out,
    output logic [PC_WIDTH-1:0] tbl_addr_out,
    output logic [9:0] mem_phys_out,
    output logic [PC_WIDTH-1:0] jump_target_out,
    output logic jump_out,
    output logic dummy_cycle_out
);

    ////////////////////////////////////////////////////////////////////
    // decoding helpers

    // register hit test, shared by every register process
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic [1:0] bank_q;
    logic [7:0] status_q;
    logic [7:0] work_q;
    logic [7:0] tbl_lo_q;
    logic [7:0] tbl_hi_q;
    logic [7:0] tbl_res_q;
    logic [7:0] rdata_q;
    logic [9:0] phys_q;
    logic [PC_WIDTH-1:0] jtgt_q;
    logic jump_q;
    logic dummy_q;
    logic [7:0] tlow_q;
    logic tvalid_q;
    logic [PC_WIDTH-1:0] taddr_q;
    csb_pkg::csb_state_t state_q;

    ////////////////////////////////////////////////////////////////////
    // alu: combinational result and flag candidates

    logic [7:0] res_d;
    logic c_d;
    logic ac_d;
    logic ov_d;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] sum7;
    logic [7:0] b_eff;
    logic cin;
    logic arith;

    always_comb begin
        b_eff = alu_operand_in;
        cin = 1'b0;
        arith = 1'b0;
        res_d = work_q;
        c_d = status_q[csb_pkg::STAT_CARRY];
        case (csb_pkg::csb_op_t'(alu_op_in))
            csb_pkg::CSB_OP_ADD: begin
                arith = 1'b1;
            end
            csb_pkg::CSB_OP_ADC: begin
                arith = 1'b1;
                cin = status_q[csb_pkg::STAT_CARRY];
            end
            // subtract as add of inverse; carry out means no borrow
            csb_pkg::CSB_OP_SUB: begin
                arith = 1'b1;
                b_eff = ~alu_operand_in;
                cin = 1'b1;
            end
            csb_pkg::CSB_OP_SBC: begin
                arith = 1'b1;
                b_eff = ~alu_operand_in;
                cin = status_q[csb_pkg::STAT_CARRY];
            end
            csb_pkg::CSB_OP_AND: res_d = work_q & alu_operand_in;
            csb_pkg::CSB_OP_OR: res_d = work_q | alu_operand_in;
            csb_pkg::CSB_OP_XOR: res_d = work_q ^ alu_operand_in;
            csb_pkg::CSB_OP_RLC: begin
                res_d = {work_q[6:0], status_q[csb_pkg::STAT_CARRY]};
                c_d = work_q[7];
            end
            csb_pkg::CSB_OP_RRC: begin
                res_d = {status_q[csb_pkg::STAT_CARRY], work_q[7:1]};
                c_d = work_q[0];
            end
            csb_pkg::CSB_OP_PASS: res_d = alu_operand_in;
            default: res_d = work_q;
        endcase
        sum9 = {1'b0, work_q} + {1'b0, b_eff} + {8'h00, cin};
        sum5 = {1'b0, work_q[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
        sum7 = {1'b0, work_q[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
        ac_d = sum5[4];
        ov_d = sum7[7] ^ sum9[8];
        if (arith) begin
            res_d = sum9[7:0];
            c_d = sum9[8];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // working register: the only alu destination

    // no port moves one data register to another directly
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            work_q <= csb_pkg::BYTE_ZERO;
        end else if (alu_go_in) begin
            work_q <= res_d;
        end else if (reg_wr_in && hit(reg_addr_in, csb_pkg::ADDR_WORK_REG)) begin
            work_q <= reg_wdata_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bank pointer

    // watchdog expiry in low power keeps the bank for resumed code
    always_ff @(posedge clk_in) begin
        if (rst_in && !(wdt_reset_in && low_power_in)) begin
            bank_q <= csb_pkg::BANK_RESET;
        end else if (!rst_in && reg_wr_in && hit(reg_addr_in, csb_pkg::ADDR_BANK_SELECT)) begin
            bank_q <= reg_wdata_in[1:0];
        end
    end

    // physical data address: sfr area and direct accesses stay in bank zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            phys_q <= 10'h000;
        end else if (mem_addr_in < csb_pkg::SFR_LIMIT || !mem_indirect_in) begin
            phys_q <= {2'b00, mem_addr_in};
        end else begin
            phys_q <= {bank_q, mem_addr_in};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status register

    // hardware event beats a same-cycle software write
    always_ff @(posedge clk_in) begin
        if (power_up_in) begin
            status_q <= csb_pkg::BYTE_ZERO;
        end else if (rst_in) begin
            status_q <= status_q;
        end else begin
            if (reg_wr_in && hit(reg_addr_in, csb_pkg::ADDR_STATUS_FLAGS)) begin
                status_q[3:0] <= reg_wdata_in[3:0];
            end
            if (alu_go_in) begin
                if (alu_affect_in[csb_pkg::AFF_C]) status_q[csb_pkg::STAT_CARRY] <= c_d;
                if (alu_affect_in[csb_pkg::AFF_AC]) status_q[csb_pkg::STAT_NIBBLE] <= ac_d;
                if (alu_affect_in[csb_pkg::AFF_Z]) status_q[csb_pkg::STAT_NIL] <= (res_d == 8'h00);
                if (alu_affect_in[csb_pkg::AFF_OV]) status_q[csb_pkg::STAT_WRAP] <= ov_d;
            end
            if (wdt_clear_in) begin
                status_q[csb_pkg::STAT_HALTED] <= 1'b0;
                status_q[csb_pkg::STAT_EXPIRY] <= 1'b0;
            end else if (halt_in) begin
                status_q[csb_pkg::STAT_HALTED] <= 1'b1;
                status_q[csb_pkg::STAT_EXPIRY] <= 1'b0;
            end
            if (wdt_timeout_in) begin
                status_q[csb_pkg::STAT_EXPIRY] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // table pointers and table read

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tbl_lo_q <= csb_pkg::BYTE_ZERO;
            tbl_hi_q <= csb_pkg::BYTE_ZERO;
        end else if (reg_wr_in) begin
            if (hit(reg_addr_in, csb_pkg::ADDR_TABLE_PTR_LOW)) tbl_lo_q <= reg_wdata_in;
            if (hit(reg_addr_in, csb_pkg::ADDR_TABLE_PTR_HIGH)) tbl_hi_q <= reg_wdata_in;
        end
    end

    // table address is presented continuously; data arrives on tbl_go_in
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            taddr_q <= '0;
            tbl_res_q <= csb_pkg::BYTE_ZERO;
            tlow_q <= csb_pkg::BYTE_ZERO;
            tvalid_q <= 1'b0;
        end else begin
            taddr_q <= PC_WIDTH'({tbl_hi_q, tbl_lo_q});
            tvalid_q <= tbl_go_in;
            if (tbl_go_in) begin
                tbl_res_q <= tbl_data_in[15:8];
                tlow_q <= tbl_data_in[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // program counter low writes: in-page jump plus dummy cycle

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= csb_pkg::CSB_ST_RUN;
            jump_q <= 1'b0;
            dummy_q <= 1'b0;
            jtgt_q <= '0;
        end else begin
            jump_q <= 1'b0;
            dummy_q <= 1'b0;
            case (state_q)
                csb_pkg::CSB_ST_RUN: begin
                    if (reg_wr_in && hit(reg_addr_in, csb_pkg::ADDR_PROG_INDEX_LOW)) begin
                        jtgt_q <= {pc_in[PC_WIDTH-1:8], reg_wdata_in};
                        jump_q <= 1'b1;
                        state_q <= csb_pkg::CSB_ST_DUMMY;
                    end
                end
                csb_pkg::CSB_ST_DUMMY: begin
                    dummy_q <= 1'b1;
                    state_q <= csb_pkg::CSB_ST_RUN;
                end
                default: state_q <= csb_pkg::CSB_ST_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register read port, data one cycle after the strobe

    // unmapped addresses read zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_q <= csb_pkg::BYTE_ZERO;
        end else if (reg_rd_in) begin
            if (hit(reg_addr_in, csb_pkg::ADDR_BANK_SELECT)) rdata_q <= {6'h00, bank_q};
            else if (hit(reg_addr_in, csb_pkg::ADDR_STATUS_FLAGS)) rdata_q <= {2'b00, status_q[5:0]};
            else if (hit(reg_addr_in, csb_pkg::ADDR_WORK_REG)) rdata_q <= work_q;
            else if (hit(reg_addr_in, csb_pkg::ADDR_PROG_INDEX_LOW)) rdata_q <= pc_in[7:0];
            else if (hit(reg_addr_in, csb_pkg::ADDR_TABLE_PTR_LOW)) rdata_q <= tbl_lo_q;
            else if (hit(reg_addr_in, csb_pkg::ADDR_TABLE_PTR_HIGH)) rdata_q <= tbl_hi_q;
            else if (hit(reg_addr_in, csb_pkg::ADDR_TABLE_RESULT_HIGH)) rdata_q <= tbl_res_q;
            else rdata_q <= csb_pkg::BYTE_ZERO;
        end else begin
            rdata_q <= csb_pkg::BYTE_ZERO;
        end
    end

    // status is never pushed: no stack port exists here
    assign reg_rdata_out = rdata_q;
    assign working_reg_out = work_q;
    assign table_low_out = tlow_q;
    assign table_low_valid_out = tvalid_q;
    assign tbl_addr_out = taddr_q;
    assign mem_phys_out = phys_q;
    assign jump_target_out = jtgt_q;
    assign jump_out = jump_q;
    assign dummy_cycle_out = dummy_q;

    ////////////////////////////////////////////////////////////////////
    // assertions

    sequence pcl_write_s;
        reg_wr_in && reg_addr_in == csb_pkg::ADDR_PROG_INDEX_LOW && state_q == csb_pkg::CSB_ST_RUN;
    endsequence

    jump_dummy_a: assert property (@(posedge clk_in) disable iff (rst_in)
        pcl_write_s |=> jump_out ##1 dummy_cycle_out) else $error("jump not followed by dummy cycle");
    bank_upper_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $past(reg_rd_in) && $past(reg_addr_in) == csb_pkg::ADDR_BANK_SELECT |-> reg_rdata_out[7:2] == 6'h00)
        else $error("bank upper bits not zero");
    direct_bank0_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !mem_indirect_in |=> mem_phys_out[9:8] == 2'b00) else $error("direct access left bank zero");
    sw_halt_a: assert property (@(posedge clk_in) disable iff (rst_in || power_up_in)
        !halt_in && !wdt_clear_in |=> status_q[csb_pkg::STAT_HALTED] == $past(status_q[csb_pkg::STAT_HALTED]))
        else $error("halted flag changed without cause");
    halt_set_a: assert property (@(posedge clk_in) disable iff (rst_in || power_up_in)
        halt_in && !wdt_clear_in |=> status_q[csb_pkg::STAT_HALTED]) else $error("halt did not set flag");
    expiry_set_a: assert property (@(posedge clk_in) disable iff (rst_in || power_up_in)
        wdt_timeout_in |=> status_q[csb_pkg::STAT_EXPIRY]) else $error("timeout did not set flag");
    nil_flag_a: assert property (@(posedge clk_in) disable iff (rst_in || power_up_in)
        alu_go_in && alu_affect_in[csb_pkg::AFF_Z] |=> status_q[csb_pkg::STAT_NIL] == (work_q == 8'h00))
        else $error("zero flag mismatch");
    flag_keep_a: assert property (@(posedge clk_in) disable iff (rst_in || power_up_in)
        alu_go_in && !alu_affect_in[csb_pkg::AFF_C] && !reg_wr_in |=> $stable(status_q[csb_pkg::STAT_CARRY]))
        else $error("unlisted carry changed");
    wr_result_a: assert property (@(posedge clk_in) disable iff (rst_in)
        alu_go_in |=> work_q == $past(res_d)) else $error("alu result not in working register");
    // a write landing in the dummy cycle must not start a second jump
    jump_pulse_a: assert property (@(posedge clk_in) disable iff (rst_in)
        jump_out |=> !jump_out) else $error("jump pulse longer than one cycle");

endmodule : csb_core

// [test/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    // every design input in one bundle, applied at the rising edge
    typedef struct packed {
        logic rst, pu, wdtr, lp, wr, rd, go, clr, halt, tmo, ind, tgo;
        logic [7:0] addr, wdata, opnd, maddr;
        logic [3:0] op, aff;
        logic [15:0] tdata;
        logic [12:0] pc;
    } csb_tb_in_t;
    typedef struct {
        int due;
        int sel;
        logic [15:0] exp;
    } csb_tb_note_t;
    logic clk_in = 1'h0;
    csb_tb_in_t din;
    csb_tb_in_t plan;
    csb_tb_note_t notes[$];
    csb_tb_note_t cur;
    logic [15:0] seen;
    int cyc = 0;
    int n_fail = 0;
    int comparisons = 0;
    logic [31:0] rng = 32'hBEB90BC1;
    logic [7:0] acc, st, tres;
    logic [1:0] bank;
    logic [7:0] reg_rdata_out, working_reg_out, table_low_out;
    logic table_low_valid_out, jump_out, dummy_cycle_out;
    logic [12:0] tbl_addr_out, jump_target_out;
    logic [9:0] mem_phys_out;
    string what[7] = '{"rdata", "work", "phys", "jump", "dummy", "tlow", "taddr"};

    always #20 clk_in = ~clk_in;

    csb_core #(.PC_WIDTH(13)) i_dut (
        .clk_in(clk_in), .rst_in(din.rst), .power_up_in(din.pu), .wdt_reset_in(din.wdtr),
        .low_power_in(din.lp), .reg_addr_in(din.addr), .reg_wdata_in(din.wdata), .reg_wr_in(din.wr),
        .reg_rd_in(din.rd), .alu_go_in(din.go), .alu_op_in(din.op),
        .alu_operand_in(din.opnd), .alu_affect_in(din.aff), .wdt_clear_in(din.clr), .halt_in(din.halt),
        .wdt_timeout_in(din.tmo), .mem_addr_in(din.maddr), .mem_indirect_in(din.ind), .tbl_go_in(din.tgo),
        .tbl_data_in(din.tdata), .pc_in(din.pc), .reg_rdata_out(reg_rdata_out),
        .working_reg_out(working_reg_out), .table_low_out(table_low_out),
        .table_low_valid_out(table_low_valid_out), .tbl_addr_out(tbl_addr_out), .mem_phys_out(mem_phys_out),
        .jump_target_out(jump_target_out), .jump_out(jump_out), .dummy_cycle_out(dummy_cycle_out)
    );

    // plan is filled at the falling edge, so no race with the design
    always @(posedge clk_in) begin
        din <= plan;
        {plan.wr, plan.rd, plan.go, plan.clr, plan.halt, plan.tmo, plan.tgo} = 7'h00;
        cyc = cyc + 1;
    end

    // oldest note is judged once its cycle comes round
    always @(negedge clk_in) begin
        while (notes.size() != 0 && notes[0].due <= cyc) begin
            cur = notes.pop_front();
            seen = observe(cur.sel);
            comparisons = comparisons + 1;
            if (cur.due != cyc || seen !== cur.exp) begin
                n_fail = n_fail + 1;
                $display("mismatch %s expected %h seen %h", what[cur.sel], cur.exp, seen);
            end
        end
    end

    ////////////////////////////////////////
    function automatic logic [15:0] observe(input int sel);
        case (sel)
            0: return {8'h00, reg_rdata_out};
            1: return {8'h00, working_reg_out};
            2: return {6'h00, mem_phys_out};
            3: return {2'h0, jump_out, jump_target_out};
            4: return {15'h0000, dummy_cycle_out};
            5: return {7'h00, table_low_valid_out, table_low_out};
            default: return {3'h0, tbl_addr_out};
        endcase
    endfunction : observe

    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : rnd

    task automatic tick();
        @(negedge clk_in);
    endtask : tick

    // lag 2: one cycle to reach the pins, one for the registered answer
    task automatic note(input int sel, input logic [15:0] exp, input int lag);
        notes.push_back(csb_tb_note_t'{cyc + lag, sel, exp});
    endtask : note

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        plan.addr = a;
        plan.wdata = d;
        plan.wr = 1'h1;
        if (a == csb_pkg::ADDR_BANK_SELECT) bank = d[1:0];
        if (a == csb_pkg::ADDR_STATUS_FLAGS) st[3:0] = d[3:0];
        if (a == csb_pkg::ADDR_WORK_REG) acc = d;
        tick();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        plan.addr = a;
        plan.rd = 1'h1;
        note(0, {8'h00, e}, 2);
        tick();
    endtask : rd

    task automatic chk_st();
        rd(csb_pkg::ADDR_STATUS_FLAGS, st);
    endtask : chk_st

    // clear beats halt on the halted bit, timeout beats both on expiry
    task automatic ev(input logic clr, input logic halt, input logic tmo);
        if (clr || halt) st[5] = 1'h0;
        if (clr) st[4] = 1'h0;
        else if (halt) st[4] = 1'h1;
        if (tmo) st[5] = 1'h1;
        {plan.clr, plan.halt, plan.tmo} = {clr, halt, tmo};
        tick();
    endtask : ev

    task automatic do_reset(input logic pu, input logic wdtr, input logic lp);
        {plan.rst, plan.pu, plan.wdtr, plan.lp} = {1'h1, pu, wdtr, lp};
        if (!(wdtr && lp)) bank = 2'h0;
        if (pu) st = 8'h00;
        acc = 8'h00;
        tick();
        {plan.rst, plan.pu, plan.wdtr, plan.lp} = 4'h0;
    endtask : do_reset

    task automatic mem(input logic [7:0] a, input logic ind);
        plan.maddr = a;
        plan.ind = ind;
        note(2, {6'h00, ((ind && a >= csb_pkg::SFR_LIMIT) ? bank : 2'h0), a}, 2);
        tick();
    endtask : mem

    // reference alu; subtract is add of the inverse, so carry means no borrow
    task automatic alu(input logic [3:0] op, input logic [7:0] b, input logic [3:0] aff);
        logic [7:0] bb;
        logic [7:0] r;
        logic [8:0] s;
        logic [4:0] lo;
        logic cin;
        logic c;
        bb = (op == csb_pkg::CSB_OP_SUB || op == csb_pkg::CSB_OP_SBC) ? ~b : b;
        cin = (op == csb_pkg::CSB_OP_SUB) | ((op == csb_pkg::CSB_OP_ADC || op == csb_pkg::CSB_OP_SBC) & st[0]);
        s = {1'h0, acc} + {1'h0, bb} + {8'h00, cin};
        lo = {1'h0, acc[3:0]} + {1'h0, bb[3:0]} + {4'h0, cin};
        c = s[8];
        r = s[7:0];
        case (op)
            csb_pkg::CSB_OP_AND: r = acc & b;
            csb_pkg::CSB_OP_OR: r = acc | b;
            csb_pkg::CSB_OP_XOR: r = acc ^ b;
            csb_pkg::CSB_OP_RLC: {c, r} = {acc, st[0]};
            csb_pkg::CSB_OP_RRC: {r, c} = {st[0], acc};
            csb_pkg::CSB_OP_PASS: r = b;
            default: c = s[8];
        endcase
        if (aff[csb_pkg::AFF_C]) st[0] = c;
        if (aff[csb_pkg::AFF_AC]) st[1] = lo[4];
        if (aff[csb_pkg::AFF_Z]) st[2] = (r == 8'h00);
        if (aff[csb_pkg::AFF_OV]) st[3] = s[8] ^ acc[7] ^ bb[7] ^ s[7];
        acc = r;
        {plan.op, plan.opnd, plan.aff, plan.go} = {op, b, aff, 1'h1};
        note(1, {8'h00, r}, 2);
        tick();
    endtask : alu

    task automatic test_done();
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////
    // a hang is cut short here
    initial begin : guard
        repeat (20000) @(posedge clk_in);
        n_fail = n_fail + 1;
        test_done();
    end

    initial begin : main
        logic [31:0] x;
        int o;
        din = '0;
        din.rst = 1'h1;
        din.pu = 1'h1;
        plan = din;
        {acc, st, tres, bank} = 26'h0;
        repeat (3) @(negedge clk_in);
        {plan.rst, plan.pu} = 2'h0;
        chk_st();
        rd(csb_pkg::ADDR_BANK_SELECT, 8'h00);
        rd(8'h3C, 8'h00);
        // each bank: direct data, indirect data, special area
        for (int b = 0; b < 4; b++) begin
            x = rnd();
            wr(csb_pkg::ADDR_BANK_SELECT, {x[7:2], b[1:0]});
            rd(csb_pkg::ADDR_BANK_SELECT, {6'h00, b[1:0]});
            mem(8'h80 | x[7:0], 1'h0);
            mem(8'h80 | x[15:8], 1'h1);
            mem({1'h0, x[22:16]}, 1'h1);
        end
        // warm resets; only power-up clears the status
        wr(csb_pkg::ADDR_BANK_SELECT, 8'h02);
        ev(1'h0, 1'h0, 1'h1);
        do_reset(1'h0, 1'h1, 1'h1);
        rd(csb_pkg::ADDR_BANK_SELECT, 8'h02);
        chk_st();
        do_reset(1'h0, 1'h1, 1'h0);
        rd(csb_pkg::ADDR_BANK_SELECT, 8'h00);
        do_reset(1'h1, 1'h0, 1'h0);
        chk_st();
        // every mix of clear, halt and timeout, with status writes between
        for (int k = 0; k < 16; k++) begin
            x = rnd();
            ev(k[0], k[1], k[2]);
            chk_st();
            wr(csb_pkg::ADDR_STATUS_FLAGS, x[7:0]);
            chk_st();
        end
        wr(csb_pkg::ADDR_WORK_REG, x[15:8]);
        rd(csb_pkg::ADDR_WORK_REG, acc);
        // random alu work; logic ops only touch zero, rotates only carry
        for (int k = 0; k < 60; k++) begin
            x = rnd();
            o = int'(x[31:24]) % 10;
            alu(o[3:0], x[15:8], (o < 4) ? x[3:0] : ((o == 7 || o == 8) ? 4'h1 : 4'h4));
            chk_st();
        end
        alu(csb_pkg::CSB_OP_XOR, acc, 4'h4);
        alu(csb_pkg::CSB_OP_PASS, 8'h7F, 4'h4);
        alu(csb_pkg::CSB_OP_ADD, 8'h01, 4'hF);
        chk_st();
        alu(csb_pkg::CSB_OP_ADD, 8'h80, 4'hF);
        chk_st();
        alu(csb_pkg::CSB_OP_SUB, acc, 4'hF);
        chk_st();
        // jumps keep the page bits, then a dummy cycle
        for (int k = 0; k < 6; k++) begin
            x = rnd();
            plan.pc = x[28:16];
            note(3, {3'h1, x[28:24], x[7:0]}, 2);
            note(4, 16'h0001, 3);
            wr(csb_pkg::ADDR_PROG_INDEX_LOW, x[7:0]);
            repeat (2) tick();
        end
        // a second write in the dummy cycle is refused; both pulses then fall
        x = rnd();
        plan.pc = x[28:16];
        note(3, {3'h1, x[28:24], x[7:0]}, 2);
        note(3, {3'h0, x[28:24], x[7:0]}, 3);
        note(4, 16'h0001, 3);
        note(4, 16'h0000, 4);
        wr(csb_pkg::ADDR_PROG_INDEX_LOW, x[7:0]);
        wr(csb_pkg::ADDR_PROG_INDEX_LOW, ~x[7:0]);
        // table reads back to back: last high byte is kept
        x = rnd();
        wr(csb_pkg::ADDR_TABLE_PTR_LOW, x[7:0]);
        wr(csb_pkg::ADDR_TABLE_PTR_HIGH, x[15:8]);
        note(6, {3'h0, x[12:0]}, 2);
        for (int k = 0; k < 2; k++) begin
            x = rnd();
            plan.tdata = x[15:0];
            plan.tgo = 1'h1;
            tres = x[15:8];
            note(5, {8'h01, x[7:0]}, 2);
            tick();
        end
        note(5, {8'h00, x[7:0]}, 2);
        rd(csb_pkg::ADDR_TABLE_RESULT_HIGH, tres);
        for (int i = 0; i < 10 && notes.size() != 0; i++) begin
            tick();
        end
        if (notes.size() != 0) begin
            n_fail = n_fail + 1;
        end
        test_done();
    end
endmodule : tb_top
